// ===== src/etb_pkg.sv
/*
 * constants and types of the status output block.
 * assumes a single 40 MHz clock and an axi4-lite register bus.
 */
package etb_pkg;

    // ************************************************************
    // clock and time base
    // ************************************************************
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned TICK_S          = 1;
    localparam int unsigned TICK_CYCLES     = CLK_HZ * TICK_S;

    // ************************************************************
    // register offsets (byte addresses)
    // ************************************************************
    localparam logic [7:0] OFS_CTRL          = 8'h00;
    localparam logic [7:0] OFS_TIME_LIMIT    = 8'h04;
    localparam logic [7:0] OFS_THERM_THRESH  = 8'h08;
    localparam logic [7:0] OFS_THERM_TRIP    = 8'h0C;
    localparam logic [7:0] OFS_OUT_SEL       = 8'h10;
    localparam logic [7:0] OFS_RUN_TIME      = 8'h14;
    localparam logic [7:0] OFS_PWR_TIME      = 8'h18;
    localparam logic [7:0] OFS_STATUS        = 8'h1C;
    localparam logic [7:0] OFS_IRQ_STATUS    = 8'h20;
    localparam logic [7:0] OFS_IRQ_MASK      = 8'h24;
    localparam logic [7:0] OFS_RUN_PRESET    = 8'h28;
    localparam logic [7:0] OFS_PWR_PRESET    = 8'h2C;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int unsigned CTRL_BRAKE_EN    = 0;
    localparam int unsigned CTRL_LOAD_RUN    = 1;
    localparam int unsigned CTRL_LOAD_PWR    = 2;
    localparam int unsigned SEL_W            = 8;
    localparam int unsigned SEL_T1_LSB       = 0;
    localparam int unsigned SEL_T2_LSB       = 8;
    localparam int unsigned SEL_RLY_LSB      = 16;
    localparam int unsigned NUM_FLAGS        = 5;

    // ************************************************************
    // selection codes
    // ************************************************************
    localparam logic [7:0] CODE_RUN_TIME     = 8'h0B;
    localparam logic [7:0] CODE_PWR_TIME     = 8'h0C;
    localparam logic [7:0] CODE_THERMAL      = 8'h0D;
    localparam logic [7:0] CODE_BRAKE_READY  = 8'h13;
    localparam logic [7:0] CODE_BRAKE_FAULT  = 8'h14;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [31:0] RST_CTRL         = 32'h0000_0000;
    localparam logic [31:0] RST_TIME_LIMIT   = 32'h0000_0000;
    localparam logic [15:0] RST_THERM_THRESH = 16'h0050;
    localparam logic [15:0] RST_THERM_TRIP   = 16'h0064;
    localparam logic [31:0] RST_OUT_SEL      = 32'h0000_0000;
    localparam logic [4:0]  RST_IRQ_MASK     = 5'h00;

    localparam logic [1:0] RESP_OKAY         = 2'b00;
    localparam logic [1:0] RESP_SLVERR       = 2'b10;

    // status flag bundle, also the layout of status, irq status and mask
    typedef struct packed {
        logic brake_fault_flag;
        logic brake_release_ready_flag;
        logic thermal_warning_flag;
        logic power_time_expired_flag;
        logic run_time_expired_flag;
    } etb_flags_t;

    typedef struct packed {
        logic [7:0] relay_sel;
        logic [7:0] term2_sel;
        logic [7:0] term1_sel;
    } etb_sel_t;

endpackage

// ===== src/etb_hours_store.sv
/*
 * two-word retained store of the run and power time counts.
 * assumes cells that survive power loss; reset never clears them.
 */
module etb_hours_store (
    input  wire logic        aclk,    // clock
    input  wire logic        we,      // write enable
    input  wire logic        waddr,   // 0 run, 1 power
    input  wire logic [31:0] wdata,   // word to store
    input  wire logic        raddr,   // word to read
    output logic      [31:0] rdata    // registered read word
);
    import etb_pkg::*;

    logic [31:0] mem [2];

    always_ff @(posedge aclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

// ===== src/etb_status_out.sv
/*
 * status output logic: run and power time expiry, thermal warning and
 * brake flags, routed by selection code to two terminals and the relay.
 * assumes synchronous inputs from the drive core and an axi4-lite master.
 */
// The implementer's own choices: the register addresses and register access over AXI4-Lite.

module etb_status_out (
    input  wire logic              aclk,             // clock
    input  wire logic              aresetn,          // sync reset, low
    input  wire logic              motor_running,    // drive is running
    input  wire logic              power_on,         // drive is powered
    input  wire logic [15:0]       thermal_level,    // accumulated motor thermal
    input  wire logic              brake_ready_in,   // brake control: release ready
    input  wire logic              brake_error_in,   // brake control: error
    input  wire logic [7:0]        s_axi_awaddr,     // write address
    input  wire logic              s_axi_awvalid,    // write address valid
    output logic                   s_axi_awready,    // write address ready
    input  wire logic [31:0]       s_axi_wdata,      // write data
    input  wire logic [3:0]        s_axi_wstrb,      // byte strobes
    input  wire logic              s_axi_wvalid,     // write data valid
    output logic                   s_axi_wready,     // write data ready
    output logic [1:0]             s_axi_bresp,      // write response
    output logic                   s_axi_bvalid,     // write response valid
    input  wire logic              s_axi_bready,     // write response ready
    input  wire logic [7:0]        s_axi_araddr,     // read address
    input  wire logic              s_axi_arvalid,    // read address valid
    output logic                   s_axi_arready,    // read address ready
    output logic [31:0]            s_axi_rdata,      // read data
    output logic [1:0]             s_axi_rresp,      // read response
    output logic                   s_axi_rvalid,     // read valid
    input  wire logic              s_axi_rready,     // read response ready
    output logic                   term1_out,        // logic output terminal 1
    output logic                   term2_out,        // logic output terminal 2
    output logic                   relay_out,        // relay coil drive
    output etb_pkg::etb_flags_t    flags_out,        // raw flag vector
    output logic                   irq               // level interrupt
);
    import etb_pkg::*;

    // ************************************************************
    // functions
    // ************************************************************
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic route(input logic [7:0] code, input etb_flags_t f);
        logic r;
        r = 1'b0;
        unique case (code)
            CODE_RUN_TIME:    r = f.run_time_expired_flag;
            CODE_PWR_TIME:    r = f.power_time_expired_flag;
            CODE_THERMAL:     r = f.thermal_warning_flag;
            CODE_BRAKE_READY: r = f.brake_release_ready_flag;
            CODE_BRAKE_FAULT: r = f.brake_fault_flag;
            default:          r = 1'b0;
        endcase
        return r;
    endfunction

    // ************************************************************
    // registers
    // ************************************************************
    logic [31:0] ctrl_q, limit_q, sel_q, run_preset_q, pwr_preset_q;
    logic [15:0] thresh_q, trip_q;
    etb_flags_t  irq_st_q, irq_mask_q, flags_q, flags_d, prev_q;
    logic [31:0] run_acc_q, pwr_acc_q;
    logic [25:0] tick_cnt_q;
    logic        tick_q;
    logic        loaded_q;
    logic [1:0]  boot_q;

    // ************************************************************
    // write channel
    // ************************************************************
    logic        aw_held_q, w_held_q;
    logic [7:0]  awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take  = s_axi_wvalid && s_axi_wready;
    wire wr_go   = aw_held_q && w_held_q && !s_axi_bvalid;
    wire [7:0] wa = awaddr_q;
    wire wr_ctrl  = wr_go && wa == OFS_CTRL;
    wire wr_limit = wr_go && wa == OFS_TIME_LIMIT;
    wire wr_thr   = wr_go && wa == OFS_THERM_THRESH;
    wire wr_trip  = wr_go && wa == OFS_THERM_TRIP;
    wire wr_sel   = wr_go && wa == OFS_OUT_SEL;
    wire wr_ist   = wr_go && wa == OFS_IRQ_STATUS;
    wire wr_imsk  = wr_go && wa == OFS_IRQ_MASK;
    wire wr_rpre  = wr_go && wa == OFS_RUN_PRESET;
    wire wr_ppre  = wr_go && wa == OFS_PWR_PRESET;
    wire wr_hit   = wr_ctrl | wr_limit | wr_thr | wr_trip | wr_sel | wr_ist
                  | wr_imsk | wr_rpre | wr_ppre;
    wire [31:0] wmerged_ctrl = merge(ctrl_q, wdata_q, wstrb_q);

    assign s_axi_awready = !aw_held_q;
    assign s_axi_wready  = !w_held_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q    <= 1'b0;
            w_held_q     <= 1'b0;
            awaddr_q     <= 8'h00;
            wdata_q      <= 32'h0000_0000;
            wstrb_q      <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                aw_held_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (w_take) begin
                w_held_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
                wstrb_q  <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held_q    <= 1'b0;
                w_held_q     <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // configuration registers
    // ************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q       <= RST_CTRL;
            limit_q      <= RST_TIME_LIMIT;
            thresh_q     <= RST_THERM_THRESH;
            trip_q       <= RST_THERM_TRIP;
            sel_q        <= RST_OUT_SEL;
            irq_mask_q   <= RST_IRQ_MASK;
            run_preset_q <= 32'h0000_0000;
            pwr_preset_q <= 32'h0000_0000;
        end else begin
            // load bits self-clear after one cycle
            ctrl_q[CTRL_LOAD_RUN] <= 1'b0;
            ctrl_q[CTRL_LOAD_PWR] <= 1'b0;
            if (wr_ctrl)  ctrl_q  <= wmerged_ctrl;
            if (wr_limit) limit_q <= merge(limit_q, wdata_q, wstrb_q);
            // threshold is clamped to at most the trip level
            if (wr_thr)   thresh_q <= (wdata_q[15:0] < trip_q) ? wdata_q[15:0] : trip_q;
            if (wr_trip)  trip_q  <= wdata_q[15:0];
            if (wr_sel)   sel_q   <= merge(sel_q, wdata_q, wstrb_q);
            if (wr_imsk)  irq_mask_q <= wdata_q[NUM_FLAGS-1:0];
            if (wr_rpre)  run_preset_q <= wdata_q;
            if (wr_ppre)  pwr_preset_q <= wdata_q;
        end
    end

    // ************************************************************
    // accumulators: one second tick, retained store
    // ************************************************************
    // live counts are reloaded from the store after reset so the
    // totals survive a power cycle of the logic
    logic        st_we, st_waddr;
    logic [31:0] st_wdata, st_rdata;

    etb_hours_store u_store (
        .aclk  (aclk),
        .we    (st_we),
        .waddr (st_waddr),
        .wdata (st_wdata),
        .raddr (boot_q[0]),
        .rdata (st_rdata)
    );

    wire tick_wrap = tick_cnt_q == 26'(TICK_CYCLES - 1);
    wire run_adv   = tick_q && motor_running && power_on && loaded_q;
    wire pwr_adv   = tick_q && power_on && loaded_q;
    wire ld_run    = ctrl_q[CTRL_LOAD_RUN];
    wire ld_pwr    = ctrl_q[CTRL_LOAD_PWR];
    wire [31:0] run_next = ld_run ? run_preset_q : run_acc_q + 32'd1;
    wire [31:0] pwr_next = ld_pwr ? pwr_preset_q : pwr_acc_q + 32'd1;

    // run has priority for the store port; power advances only on ticks where run does not
    assign st_we    = (run_adv || ld_run || pwr_adv || ld_pwr) && loaded_q;
    assign st_waddr = !(run_adv || ld_run);
    assign st_wdata = st_waddr ? pwr_next : run_next;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tick_cnt_q <= 26'h000_0000;
            tick_q     <= 1'b0;
            boot_q     <= 2'b00;
            loaded_q   <= 1'b0;
            run_acc_q  <= 32'h0000_0000;
            pwr_acc_q  <= 32'h0000_0000;
        end else begin
            tick_cnt_q <= tick_wrap ? 26'h000_0000 : tick_cnt_q + 26'd1;
            tick_q     <= tick_wrap;
            if (!loaded_q) begin
                boot_q <= boot_q + 2'd1;
                if (boot_q == 2'd1) run_acc_q <= st_rdata;
                if (boot_q == 2'd2) begin
                    pwr_acc_q <= st_rdata;
                    loaded_q  <= 1'b1;
                end
            end else begin
                if (run_adv || ld_run) run_acc_q <= run_next;
                if ((pwr_adv && !(run_adv || ld_run)) || ld_pwr) pwr_acc_q <= pwr_next;
            end
        end
    end

    // ************************************************************
    // flags and routing
    // ************************************************************
    wire brake_en = ctrl_q[CTRL_BRAKE_EN];
    always_comb begin
        flags_d = '0;
        flags_d.run_time_expired_flag    = run_acc_q > limit_q;
        flags_d.power_time_expired_flag  = pwr_acc_q > limit_q;
        flags_d.thermal_warning_flag     = thermal_level > thresh_q;
        flags_d.brake_release_ready_flag = brake_en && brake_ready_in;
        flags_d.brake_fault_flag         = brake_en && brake_error_in;
    end

    etb_sel_t sel;
    assign sel = sel_q[23:0];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            flags_q   <= '0;
            prev_q    <= '0;
            irq_st_q  <= '0;
            term1_out <= 1'b0;
            term2_out <= 1'b0;
            relay_out <= 1'b0;
        end else begin
            flags_q   <= flags_d;
            prev_q    <= flags_q;
            term1_out <= route(sel.term1_sel, flags_q);
            term2_out <= route(sel.term2_sel, flags_q);
            relay_out <= route(sel.relay_sel, flags_q);
            // rising edges set, write one clears, set wins
            irq_st_q  <= (irq_st_q & ~(wr_ist ? wdata_q[NUM_FLAGS-1:0] : 5'h00))
                       | (flags_q & ~prev_q);
        end
    end

    assign flags_out = flags_q;
    assign irq       = |(irq_st_q & irq_mask_q);

    // ************************************************************
    // read channel
    // ************************************************************
    logic [31:0] rd_mux;
    logic        rd_hit;
    always_comb begin
        rd_hit = 1'b1;
        unique case (s_axi_araddr)
            OFS_CTRL:         rd_mux = ctrl_q;
            OFS_TIME_LIMIT:   rd_mux = limit_q;
            OFS_THERM_THRESH: rd_mux = {16'h0000, thresh_q};
            OFS_THERM_TRIP:   rd_mux = {16'h0000, trip_q};
            OFS_OUT_SEL:      rd_mux = {8'h00, sel_q[23:0]};
            OFS_RUN_TIME:     rd_mux = run_acc_q;
            OFS_PWR_TIME:     rd_mux = pwr_acc_q;
            OFS_STATUS:       rd_mux = {27'h000_0000, flags_q};
            OFS_IRQ_STATUS:   rd_mux = {27'h000_0000, irq_st_q};
            OFS_IRQ_MASK:     rd_mux = {27'h000_0000, irq_mask_q};
            OFS_RUN_PRESET:   rd_mux = run_preset_q;
            OFS_PWR_PRESET:   rd_mux = pwr_preset_q;
            default: begin
                rd_mux = 32'h0000_0000;
                rd_hit = 1'b0;
            end
        endcase
    end

    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_mux;
            s_axi_rresp  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule

// ===== verification/etb_status_out_checker.sv
/*
 * checks on the status block: bus answers, flag sources, reset.
 * assumes it is bound onto etb_status_out and sees only its ports.
 */
module etb_status_out_checker (
    input wire logic                aclk,           // clock
    input wire logic                aresetn,        // sync reset, low
    input wire logic                brake_ready_in, // brake ready
    input wire logic                brake_error_in, // brake error
    input wire logic                s_axi_awvalid,  // aw valid
    input wire logic                s_axi_awready,  // aw ready
    input wire logic                s_axi_wvalid,   // w valid
    input wire logic                s_axi_wready,   // w ready
    input wire logic                s_axi_bvalid,   // b valid
    input wire logic                s_axi_bready,   // b ready
    input wire logic                s_axi_arvalid,  // ar valid
    input wire logic                s_axi_arready,  // ar ready
    input wire logic                s_axi_rvalid,   // r valid
    input wire logic                s_axi_rready,   // r ready
    input wire logic [31:0]         s_axi_rdata,    // read data
    input wire logic                term1_out,      // terminal 1
    input wire logic                term2_out,      // terminal 2
    input wire logic                relay_out,      // relay
    input wire etb_pkg::etb_flags_t flags_out,      // flags
    input wire logic                irq             // interrupt
);
    import etb_pkg::*;
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_both;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    chk_reset_quiet: assert property (!$past(aresetn) |-> !term1_out && !term2_out
        && !relay_out && flags_out == '0 && !irq && !s_axi_bvalid && !s_axi_rvalid)
        else $error("outputs not quiet after reset");
    chk_write_answer: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    chk_read_answer: assert property (rd_taken |-> ##[1:2] s_axi_rvalid)
        else $error("read response missing");
    chk_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    chk_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data not held");
    chk_brake_ready: assert property (
        flags_out.brake_release_ready_flag |-> $past(brake_ready_in))
        else $error("brake ready flag without cause");
    chk_brake_fault: assert property (
        flags_out.brake_fault_flag |-> $past(brake_error_in))
        else $error("brake fault flag without cause");
    chk_term1_source: assert property (term1_out |-> $past(flags_out) != '0)
        else $error("terminal 1 on with no flag");
    chk_term2_source: assert property (term2_out |-> $past(flags_out) != '0)
        else $error("terminal 2 on with no flag");
    chk_relay_source: assert property (relay_out |-> $past(flags_out) != '0)
        else $error("relay on with no flag");
endmodule

bind etb_status_out etb_status_out_checker i_etb_status_out_checker (.aclk, .aresetn,
    .brake_ready_in, .brake_error_in, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .term1_out, .term2_out, .relay_out,
    .flags_out, .irq);

// ===== verification/etb_load_model.sv
/*
 * relay coil and contacts hung on the relay output.
 * assumes a coil energised while relay_out is high.
 */
module etb_load_model (
    input  wire logic aclk,      // clock
    input  wire logic relay_out, // coil drive
    output logic      contact_a, // closed to common while energised
    output logic      contact_b  // closed to common while released
);
    // one cycle of armature lag, far shorter than a real relay
    always_ff @(posedge aclk) begin
        contact_a <= relay_out;
        contact_b <= !relay_out;
    end
endmodule

// ===== verification/etb_status_out_test.sv
/*
 * bench of the status block: routing rows, brake, clamp, irq, retention.
 * assumes etb_status_out, its checker and the relay load model.
 */
module etb_status_out_test;
    timeunit 1ns;
    timeprecision 1ps;
    import etb_pkg::*;
    typedef struct packed {
        logic [7:0]  lim;
        logic [15:0] th;
        logic        br;
        logic        be;
        logic [7:0]  code;
        logic        exp;
    } etb_row_t;
    logic        aclk = 1'b0, aresetn = 1'b0, motor_running = 1'b0, power_on = 1'b1;
    logic        brake_ready_in = 1'b0, brake_error_in = 1'b0;
    logic [15:0] thermal_level = 16'h0000;
    logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    logic        term1_out, term2_out, relay_out, irq, contact_a, contact_b;
    etb_flags_t  flags_out;
    int          failures = 0, n_tests = 0, cyc = 0;
    etb_row_t    rows [12] = '{'{8'h04, 16'h0060, 1'b0, 1'b0, 8'h0B, 1'b1},
        '{8'h05, 16'h0060, 1'b0, 1'b0, 8'h0B, 1'b0}, '{8'h02, 16'h0000, 1'b0, 1'b0, 8'h0C, 1'b1},
        '{8'h03, 16'h0000, 1'b0, 1'b0, 8'h0C, 1'b0}, '{8'h09, 16'h0051, 1'b0, 1'b0, 8'h0D, 1'b1},
        '{8'h09, 16'h0050, 1'b0, 1'b0, 8'h0D, 1'b0}, '{8'h09, 16'h0000, 1'b1, 1'b0, 8'h13, 1'b1},
        '{8'h09, 16'h0000, 1'b0, 1'b1, 8'h13, 1'b0}, '{8'h09, 16'h0000, 1'b0, 1'b1, 8'h14, 1'b1},
        '{8'h09, 16'h0000, 1'b1, 1'b0, 8'h14, 1'b0}, '{8'h00, 16'h00FF, 1'b1, 1'b1, 8'h15, 1'b0},
        '{8'h00, 16'h00FF, 1'b1, 1'b1, 8'h00, 1'b0}};

    etb_status_out i_etb_status_out (.aclk, .aresetn, .motor_running, .power_on,
        .thermal_level, .brake_ready_in, .brake_error_in, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .term1_out, .term2_out, .relay_out, .flags_out, .irq);
    etb_load_model i_etb_load_model (.aclk, .relay_out, .contact_a, .contact_b);

    always #12.5 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures = failures + 1;
            stop_test();
        end
    end

    // ************************************************************
    // bus and compare tasks
    // ************************************************************
    task automatic axw(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!tb) begin
            @(posedge aclk);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            tb = s_axi_bvalid && s_axi_bready;
            r = s_axi_bresp;
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            if (tb) s_axi_bready <= 1'b0;
        end
    endtask
    task automatic axr(input logic [7:0] a);
        logic ta, tr;
        tr = 1'b0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!tr) begin
            @(posedge aclk);
            ta = s_axi_arvalid && s_axi_arready;
            tr = s_axi_rvalid && s_axi_rready;
            d = s_axi_rdata;
            r = s_axi_rresp;
            if (ta) s_axi_arvalid <= 1'b0;
            if (tr) s_axi_rready <= 1'b0;
        end
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests = n_tests + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axr(a);
        chk(d, exp);
    endtask
    // flag, terminal and contact each take one cycle
    task automatic settle();
        repeat (3) @(posedge aclk);
        @(negedge aclk);
    endtask
    task automatic stop_test();
        $display("comparisons %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        // loads one at a time: they share the store port
        axw(OFS_RUN_PRESET, 32'h0000_0005);
        axw(OFS_PWR_PRESET, 32'h0000_0003);
        axw(OFS_CTRL, 32'h0000_0003);
        axw(OFS_CTRL, 32'h0000_0005);
        rd_chk(OFS_RUN_TIME, 32'h0000_0005);
        foreach (rows[i]) begin
            @(posedge aclk);
            thermal_level <= rows[i].th;
            brake_ready_in <= rows[i].br;
            brake_error_in <= rows[i].be;
            axw(OFS_TIME_LIMIT, {24'h00_0000, rows[i].lim});
            axw(OFS_OUT_SEL, {8'h00, rows[i].code, rows[i].code, rows[i].code});
            settle();
            chk({29'h0, term1_out, term2_out, relay_out}, {29'h0, {3{rows[i].exp}}});
            chk({30'h0, contact_a, contact_b}, {30'h0, rows[i].exp, !rows[i].exp});
        end
        rd_chk(OFS_STATUS, 32'h0000_001F);
        axw(OFS_CTRL, 32'h0000_0000);
        axw(OFS_OUT_SEL, 32'h0000_1413);
        settle();
        chk({27'h0, flags_out, term1_out, term2_out}, {27'h0, 5'h07, 2'b00});
        axw(OFS_CTRL, 32'h0000_0001);
        settle();
        chk({30'h0, term1_out, term2_out}, 32'h0000_0003);
        axw(OFS_THERM_THRESH, 32'h0000_0070);
        rd_chk(OFS_THERM_THRESH, 32'h0000_0064);
        @(posedge aclk);
        thermal_level <= 16'h0000;
        settle();
        axw(OFS_IRQ_STATUS, 32'h0000_001F);
        @(posedge aclk);
        thermal_level <= 16'h0070;
        settle();
        rd_chk(OFS_IRQ_STATUS, 32'h0000_0004);
        chk({31'h0, irq}, 32'h0000_0000);
        axw(OFS_IRQ_MASK, 32'h0000_0004);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0000_0001);
        axw(OFS_IRQ_STATUS, 32'h0000_0004);
        @(negedge aclk);
        chk({31'h0, irq}, 32'h0000_0000);
        rd_chk(8'h30, 32'h0000_0000);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        axw(8'h30, 32'h0000_0001);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        axw(OFS_RUN_TIME, 32'h0000_0099);
        rd_chk(OFS_RUN_TIME, 32'h0000_0005);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        rd_chk(OFS_RUN_TIME, 32'h0000_0005);
        rd_chk(OFS_PWR_TIME, 32'h0000_0003);
        rd_chk(OFS_THERM_THRESH, {16'h0000, RST_THERM_THRESH});
        rd_chk(OFS_OUT_SEL, RST_OUT_SEL);
        rd_chk(OFS_IRQ_MASK, {27'h0, RST_IRQ_MASK});
        chk({29'h0, term1_out, term2_out, relay_out}, 32'h0000_0000);
        stop_test();
    end
endmodule
